// [shared/csfw_regs.svh]
// register offsets, bit positions, reset values and codes of the status word bank
`ifndef CSFW_REGS_SVH
`define CSFW_REGS_SVH

`define CSFW_ADDR_W 4
`define CSFW_OFF_FLAGS 4'h0
`define CSFW_OFF_MODE 4'h1
`define CSFW_OFF_EVENT 4'h2
`define CSFW_BIT_CARRY 0
`define CSFW_BIT_OVFL 1
`define CSFW_BIT_ZERO 2
`define CSFW_BIT_SIGN 3
`define CSFW_BIT_EXT_IO 8
`define CSFW_BIT_PRIM_PROTO 10
`define CSFW_BIT_ACT_PROTO 11
`define CSFW_BIT_VARIANT 12
`define CSFW_BIT_FORCE_EN 5
`define CSFW_BIT_FORCE_INST 6
`define CSFW_FLAGS_WMASK 16'h1500
`define CSFW_FLAGS_RESET 16'h0000
`define CSFW_EVT_OVTRAP 0
`define CSFW_EVT_MAJOR 1
`define CSFW_FAULT_UNUSED_OUT 16'h0041
`define CSFW_MODE_W 5

`endif

// [shared/csfw_pkg.sv]
// types shared by the status word bank
package csfw_pkg;

  typedef enum logic [5:0] {
    CSFW_MODE_DOWNLOAD = 6'h01,
    CSFW_MODE_PROGRAM = 6'h02,
    CSFW_MODE_SUSPEND = 6'h04,
    CSFW_MODE_RUN = 6'h08,
    CSFW_MODE_TEST_CONT = 6'h10,
    CSFW_MODE_TEST_SINGLE = 6'h20
  } csfw_mode_t;

  typedef enum logic [1:0] {
    CSFW_CTX_MAIN = 2'h1,
    CSFW_CTX_ISR = 2'h2
  } csfw_ctx_t;

endpackage

// [hw/csfw_flag_save.sv]
// shadow store for the four arithmetic flags across an interrupt routine
`timescale 1ns/1ps
`default_nettype none
module csfw_flag_save (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic save_in,
  input wire logic [3:0] flags_in,
  output logic [3:0] saved_out
);

  // capture on routine entry
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      saved_out <= 4'h0;
    end else if (ce_in && save_in) begin
      saved_out <= flags_in;
    end
  end

endmodule
`default_nettype wire

// [hw/csfw_status_bank.sv]
// status words 0 and 1 of the controller with flag logic and mode tracking
// What this block does
// - carry set on unsigned carry or borrow, cleared otherwise
// - overflow set when result does not fit destination, else cleared
// - overflow also sets overflow trap, unless encoder overflow exception
// - zero flag follows zero result of qualifying instruction
// - sign flag follows negative result of qualifying instruction
// - flags saved on interrupt routine entry, restored on return
// - flags hold until next qualifying instruction updates them
// - unused output with expansion permission clear raises fault 41h
// - primary protocol bit picks first protocol tried, 0 is A
// - active protocol bit updated at each protocol switch
// - variant bit reports configured protocol A variant, 0 full duplex
// - word 1 bits 0 to 4 encode controller mode
// - suspend instruction in run or either test mode enters suspend idle code 3 and halts, ignored in download or program
// - forces enabled bit always reads one
// - forces installed bit set while user forces are applied
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "csfw_regs.svh"
module csfw_status_bank (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [`CSFW_ADDR_W-1:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [15:0] RDATA_OUT,
  input wire logic ALU_UPDATE_IN,
  input wire logic ALU_CARRY_IN,
  input wire logic ALU_OVERFLOW_IN,
  input wire logic ALU_ZERO_IN,
  input wire logic ALU_SIGN_IN,
  input wire logic ENC_OVF_EXCEPTION_IN,
  input wire logic ROUTINE_ENTER_IN,
  input wire logic ROUTINE_EXIT_IN,
  input wire logic UNUSED_OUTPUT_ON_IN,
  input wire logic PROTO_SWITCH_IN,
  input wire logic PROTO_SWITCH_TO_B_IN,
  input wire logic VARIANT_HALF_DUPLEX_IN,
  input wire logic MODE_REQ_IN,
  input wire logic [`CSFW_MODE_W-1:0] MODE_CODE_IN,
  input wire logic SUSPEND_INSTR_IN,
  input wire logic FORCES_APPLIED_IN,
  output logic OVERFLOW_TRAP_OUT,
  output logic MAJOR_FAULT_OUT,
  output logic [15:0] FAULT_CODE_OUT,
  output logic HALTED_OUT,
  output logic PROTO_FIRST_B_OUT
);

  // ***************************************************
  // state
  // ***************************************************
  logic [3:0] arith;
  logic ext_io;
  logic prim_proto;
  logic act_proto;
  logic variant;
  logic forces_inst;
  logic ov_trap;
  logic major;
  logic [15:0] rdata;
  csfw_pkg::csfw_mode_t mode;
  csfw_pkg::csfw_ctx_t ctx;
  logic [3:0] saved;

  // ***************************************************
  // decode
  // ***************************************************
  function automatic logic hit(input logic [`CSFW_ADDR_W-1:0] a, input logic [`CSFW_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [4:0] mode_code(input csfw_pkg::csfw_mode_t m);
    logic [4:0] c;
    c = 5'h00;
    unique case (m)
      csfw_pkg::CSFW_MODE_DOWNLOAD: c = 5'h00;
      csfw_pkg::CSFW_MODE_PROGRAM: c = 5'h01;
      csfw_pkg::CSFW_MODE_SUSPEND: c = 5'h03;
      csfw_pkg::CSFW_MODE_RUN: c = 5'h06;
      csfw_pkg::CSFW_MODE_TEST_CONT: c = 5'h07;
      csfw_pkg::CSFW_MODE_TEST_SINGLE: c = 5'h08;
      default: c = 5'h01;
    endcase
    mode_code = c;
  endfunction

  wire wr_flags = WR_IN && hit(ADDR_IN, `CSFW_OFF_FLAGS);
  wire wr_event = WR_IN && hit(ADDR_IN, `CSFW_OFF_EVENT);
  wire offline = (mode == csfw_pkg::CSFW_MODE_PROGRAM) || (mode == csfw_pkg::CSFW_MODE_DOWNLOAD);
  wire wr_static = wr_flags && offline;
  // routines do not nest
  wire in_isr = (ctx == csfw_pkg::CSFW_CTX_ISR);
  wire restore = ROUTINE_EXIT_IN && in_isr;
  wire fault_evt = UNUSED_OUTPUT_ON_IN && !ext_io;
  wire trap_evt = ALU_UPDATE_IN && ALU_OVERFLOW_IN && !ENC_OVF_EXCEPTION_IN;

  // word images; reserved bits stay zero
  wire [15:0] flags_word;
  wire [15:0] mode_word;
  wire [15:0] event_word;
  assign flags_word = {
    3'h0, // bits 15 to 13 reserved
    variant, // bit 12
    act_proto, // bit 11
    prim_proto, // bit 10
    1'b0, // bit 9 reserved
    ext_io, // bit 8
    4'h0, // bits 7 to 4 reserved
    arith // bits 3 to 0
  };
  assign mode_word = {9'h000, forces_inst, 1'b1, mode_code(mode)};
  assign event_word = {14'h0000, major, ov_trap};
  wire [15:0] next_rdata = hit(ADDR_IN, `CSFW_OFF_FLAGS) ? flags_word :
                           hit(ADDR_IN, `CSFW_OFF_MODE) ? mode_word :
                           hit(ADDR_IN, `CSFW_OFF_EVENT) ? event_word : 16'h0000;

  // ***************************************************
  // arithmetic flags
  // ***************************************************
  // update from alu
  wire [3:0] alu_flags = {ALU_SIGN_IN, ALU_ZERO_IN, ALU_OVERFLOW_IN, ALU_CARRY_IN};
  // restore beats an update in the same cycle
  // hold unless updated
  wire [3:0] next_arith = restore ? saved : (ALU_UPDATE_IN ? alu_flags : arith);

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      arith <= 4'h0;
    end else if (CE_IN) begin
      arith <= next_arith;
    end
  end

  // shadow taken before this cycle's update
  // save on entry
  csfw_flag_save u_save (
    .clk_in(CLK_IN),
    .rst_n_in(RST_N_IN),
    .ce_in(CE_IN),
    .save_in(ROUTINE_ENTER_IN && !in_isr),
    .flags_in(arith),
    .saved_out(saved)
  );

  // routine context tracker
  // a nested entry must not overwrite the shadow copy
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ctx <= csfw_pkg::CSFW_CTX_MAIN;
    end else if (CE_IN) begin
      unique case (ctx)
        csfw_pkg::CSFW_CTX_MAIN: begin
          if (ROUTINE_ENTER_IN) begin
            ctx <= csfw_pkg::CSFW_CTX_ISR;
          end
        end
        csfw_pkg::CSFW_CTX_ISR: begin
          if (ROUTINE_EXIT_IN) begin
            ctx <= csfw_pkg::CSFW_CTX_MAIN;
          end
        end
        default: ctx <= csfw_pkg::CSFW_CTX_MAIN;
      endcase
    end
  end

  // ***************************************************
  // configuration and protocol bits
  // ***************************************************
  // offline writes only, others dropped
  // primary protocol selection
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ext_io <= 1'b0;
      prim_proto <= 1'b0;
    end else if (CE_IN && wr_static) begin
      ext_io <= WDATA_IN[`CSFW_BIT_EXT_IO];
      prim_proto <= WDATA_IN[`CSFW_BIT_PRIM_PROTO];
    end
  end

  // driven by the link layer, not software
  // active protocol on switch
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      act_proto <= 1'b0;
    end else if (CE_IN && PROTO_SWITCH_IN) begin
      act_proto <= PROTO_SWITCH_TO_B_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      variant <= 1'b0;
      forces_inst <= 1'b0;
    end else if (CE_IN) begin
      variant <= VARIANT_HALF_DUPLEX_IN;
      forces_inst <= FORCES_APPLIED_IN;
    end
  end

  // ***************************************************
  // event bits, set wins over clear
  // ***************************************************
  // set sources, one per event bit
  wire [1:0] evt_set;
  wire [1:0] evt;
  assign evt_set[`CSFW_EVT_OVTRAP] = trap_evt;
  assign evt_set[`CSFW_EVT_MAJOR] = fault_evt;

  for (genvar g = 0; g < 2; g++) begin : g_evt
    logic evt_q;
    // set beats a clear in the same cycle so no event is lost
    wire next_evt = evt_set[g] || (evt_q && !(wr_event && WDATA_IN[g]));

    // one sticky event bit
    always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
        evt_q <= 1'b0;
      end else if (CE_IN) begin
        evt_q <= next_evt;
      end
    end

    assign evt[g] = evt_q;
  end

  assign ov_trap = evt[`CSFW_EVT_OVTRAP];
  assign major = evt[`CSFW_EVT_MAJOR];

  // ***************************************************
  // controller mode
  // ***************************************************
  // illegal codes keep the current mode
  function automatic csfw_pkg::csfw_mode_t decode_mode(input logic [4:0] c, input csfw_pkg::csfw_mode_t cur);
    csfw_pkg::csfw_mode_t m;
    m = cur;
    case (c)
      5'h00: m = csfw_pkg::CSFW_MODE_DOWNLOAD;
      5'h01: m = csfw_pkg::CSFW_MODE_PROGRAM;
      5'h03: m = csfw_pkg::CSFW_MODE_SUSPEND;
      5'h06: m = csfw_pkg::CSFW_MODE_RUN;
      5'h07: m = csfw_pkg::CSFW_MODE_TEST_CONT;
      5'h08: m = csfw_pkg::CSFW_MODE_TEST_SINGLE;
      default: m = cur;
    endcase
    decode_mode = m;
  endfunction

  wire running = (mode == csfw_pkg::CSFW_MODE_RUN) || (mode == csfw_pkg::CSFW_MODE_TEST_CONT) ||
                 (mode == csfw_pkg::CSFW_MODE_TEST_SINGLE);
  csfw_pkg::csfw_mode_t next_mode;
  assign next_mode = (SUSPEND_INSTR_IN && running) ? csfw_pkg::CSFW_MODE_SUSPEND :
                     MODE_REQ_IN ? decode_mode(MODE_CODE_IN, mode) : mode;

  // reset lands in program mode so static bits are writable
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      mode <= csfw_pkg::CSFW_MODE_PROGRAM;
    end else if (CE_IN) begin
      mode <= next_mode;
    end
  end

  // ***************************************************
  // read port and outputs
  // ***************************************************
  // read data registered one cycle after strobe
  // zero outside the read slot on enabled cycles, last word held while CE_IN is low
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rdata <= 16'h0000;
    end else if (CE_IN) begin
      rdata <= RD_IN ? next_rdata : 16'h0000;
    end
  end

  assign RDATA_OUT = rdata;
  assign OVERFLOW_TRAP_OUT = ov_trap;
  assign MAJOR_FAULT_OUT = major;
  // one fault source, so the code follows the sticky bit
  assign FAULT_CODE_OUT = major ? `CSFW_FAULT_UNUSED_OUT : 16'h0000;
  assign HALTED_OUT = (mode == csfw_pkg::CSFW_MODE_SUSPEND);
  assign PROTO_FIRST_B_OUT = prim_proto;

endmodule
`default_nettype wire

// [verif/csfw_status_bank_monitor.sv]
// assertion checker on the status word bank ports
`timescale 1ns/1ps
`default_nettype none
module csfw_status_bank_monitor (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic [3:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [15:0] RDATA_OUT,
  input wire logic ALU_UPDATE_IN,
  input wire logic ALU_OVERFLOW_IN,
  input wire logic ENC_OVF_EXCEPTION_IN,
  input wire logic ROUTINE_EXIT_IN,
  input wire logic UNUSED_OUTPUT_ON_IN,
  input wire logic MODE_REQ_IN,
  input wire logic [4:0] MODE_CODE_IN,
  input wire logic SUSPEND_INSTR_IN,
  input wire logic OVERFLOW_TRAP_OUT,
  input wire logic MAJOR_FAULT_OUT,
  input wire logic [15:0] FAULT_CODE_OUT,
  input wire logic HALTED_OUT
);
  // ****
  // port checks
  // ****
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // read requests of words 0 and 1
  sequence s_rd_flags;
    RD_IN && ADDR_IN == 4'h0;
  endsequence
  sequence s_rd_mode;
    RD_IN && ADDR_IN == 4'h1;
  endsequence
  // properties
  property p_rd_idle;
    $past(CE_IN) && !$past(RD_IN) |-> RDATA_OUT == 16'h0000;
  endproperty
  property p_rsvd;
    s_rd_flags |=> (RDATA_OUT & 16'he2f0) == 16'h0000;
  endproperty
  property p_force_en;
    s_rd_mode |=> RDATA_OUT[5];
  endproperty
  property p_code;
    FAULT_CODE_OUT == (MAJOR_FAULT_OUT ? 16'h0041 : 16'h0000);
  endproperty
  property p_flt_rise;
    $rose(MAJOR_FAULT_OUT) |-> $past(UNUSED_OUTPUT_ON_IN);
  endproperty
  property p_flt_fall;
    $fell(MAJOR_FAULT_OUT) |-> $past(WR_IN) && $past(ADDR_IN) == 4'h2 && $past(WDATA_IN[1]);
  endproperty
  property p_trap_set;
    CE_IN && ALU_UPDATE_IN && ALU_OVERFLOW_IN && !ENC_OVF_EXCEPTION_IN |=> OVERFLOW_TRAP_OUT;
  endproperty
  property p_trap_rise;
    $rose(OVERFLOW_TRAP_OUT) |-> $past(ALU_UPDATE_IN) && $past(ALU_OVERFLOW_IN) && !$past(ENC_OVF_EXCEPTION_IN);
  endproperty
  property p_halt;
    $rose(HALTED_OUT) |-> $past(SUSPEND_INSTR_IN) || $past(MODE_REQ_IN) && $past(MODE_CODE_IN) == 5'h03;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  a_force_en: assert property (p_force_en) else $error("forces enabled low");
  a_code: assert property (p_code) else $error("bad fault code");
  a_flt_rise: assert property (p_flt_rise) else $error("fault without cause");
  a_flt_fall: assert property (p_flt_fall) else $error("fault lost");
  a_trap_set: assert property (p_trap_set) else $error("trap missing");
  a_trap_rise: assert property (p_trap_rise) else $error("trap without cause");
  a_halt: assert property (p_halt) else $error("halt without cause");
endmodule
bind csfw_status_bank csfw_status_bank_monitor i_mon (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN),
  .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .ALU_UPDATE_IN(ALU_UPDATE_IN), .ALU_OVERFLOW_IN(ALU_OVERFLOW_IN),
  .ENC_OVF_EXCEPTION_IN(ENC_OVF_EXCEPTION_IN), .ROUTINE_EXIT_IN(ROUTINE_EXIT_IN),
  .UNUSED_OUTPUT_ON_IN(UNUSED_OUTPUT_ON_IN), .MODE_REQ_IN(MODE_REQ_IN), .MODE_CODE_IN(MODE_CODE_IN),
  .SUSPEND_INSTR_IN(SUSPEND_INSTR_IN), .OVERFLOW_TRAP_OUT(OVERFLOW_TRAP_OUT),
  .MAJOR_FAULT_OUT(MAJOR_FAULT_OUT), .FAULT_CODE_OUT(FAULT_CODE_OUT), .HALTED_OUT(HALTED_OUT)
);
`default_nettype wire

// [verif/csfw_status_bank_tb.sv]
// bench for the status word bank
`timescale 1ns/1ps
`default_nettype none
module csfw_status_bank_tb;
  // ****
  // stimulus and checking
  // ****
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, trp = 1'b0, ce = 1'b1;
  logic trap, flt, halt, pfb;
  logic [1:0] lv = 2'h0; // forces, variant
  logic [3:0] adr = 4'h0, fl;
  logic [4:0] dat = 5'h00, md = 5'h01;
  logic [6:0] pl = 7'h00; // event strobes
  logic [15:0] wd = 16'h0000, rdat, fcode;
  logic [15:0] expq[$];
  logic [31:0] seed = 32'hd9f42830;
  logic [4:0] codes[8] = '{5'h00, 5'h01, 5'h03, 5'h06, 5'h07, 5'h08, 5'h02, 5'h06};
  int errors = 0, n_checks = 0;
  always #25 clk = ~clk;
  csfw_status_bank i_dut (
    .CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .ADDR_IN(adr), .WDATA_IN(wd), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdat), .ALU_UPDATE_IN(pl[0]), .ALU_CARRY_IN(dat[0]),
    .ALU_OVERFLOW_IN(dat[1]), .ALU_ZERO_IN(dat[2]), .ALU_SIGN_IN(dat[3]),
    .ENC_OVF_EXCEPTION_IN(dat[4]), .ROUTINE_ENTER_IN(pl[1]), .ROUTINE_EXIT_IN(pl[2]),
    .UNUSED_OUTPUT_ON_IN(pl[3]), .PROTO_SWITCH_IN(pl[4]), .PROTO_SWITCH_TO_B_IN(dat[0]),
    .VARIANT_HALF_DUPLEX_IN(lv[0]), .MODE_REQ_IN(pl[5]), .MODE_CODE_IN(dat),
    .SUSPEND_INSTR_IN(pl[6]), .FORCES_APPLIED_IN(lv[1]), .OVERFLOW_TRAP_OUT(trap),
    .MAJOR_FAULT_OUT(flt), .FAULT_CODE_OUT(fcode), .HALTED_OUT(halt), .PROTO_FIRST_B_OUT(pfb)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bus cycles, the read notes its expectation
  task automatic wrw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdw(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    adr <= a;
    rd <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  // one-cycle event with its qualifying data
  task automatic pulse(input logic [6:0] m, input logic [4:0] d);
    @(posedge clk);
    pl <= m;
    dat <= d;
    @(posedge clk);
    pl <= 7'h00;
    @(negedge clk);
  endtask
  // read data compared with the oldest note
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) if (rd_d) check(rdat, expq.pop_front());
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdw(4'h0, 16'h0000);
    rdw(4'h1, 16'h0021);
    rdw(4'h5, 16'h0000);
    pulse(7'h08, 5'h00);
    check(fcode, 16'h0041);
    rdw(4'h2, 16'h0002);
    wrw(4'h2, 16'h0002);
    wrw(4'h0, 16'hefff);
    @(negedge clk);
    check(flt, 1'b0);
    check(fcode, 16'h0000);
    check(pfb, 1'b1);
    pulse(7'h08, 5'h00);
    check(flt, 1'b0);
    @(posedge clk) lv <= 2'h3;
    pulse(7'h10, 5'h01);
    rdw(4'h0, 16'h1d00);
    rdw(4'h1, 16'h0061);
    lv <= 2'h2;
    pulse(7'h10, 5'h00);
    rdw(4'h0, 16'h0500);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      fl = seed[3:0];
      trp = trp | (seed[1] & ~seed[4]);
      pulse(7'h01, seed[4:0]);
      check(trap, trp);
      repeat (2) @(posedge clk);
      rdw(4'h0, {12'h050, fl});
    end
    wrw(4'h2, 16'h0001);
    pulse(7'h01, 5'h12);
    check(trap, 1'b0);
    pulse(7'h01, 5'h05);
    pulse(7'h02, 5'h00);
    pulse(7'h01, 5'h0a);
    rdw(4'h0, 16'h050a);
    pulse(7'h04, 5'h00);
    rdw(4'h0, 16'h0505);
    @(posedge clk) ce <= 1'b0;
    pulse(7'h01, 5'h0c);
    @(posedge clk) ce <= 1'b1;
    rdw(4'h0, 16'h0505);
    foreach (codes[k]) begin
      pulse(7'h20, codes[k]);
      if (codes[k] != 5'h02) md = codes[k];
      check(halt, md == 5'h03);
      rdw(4'h1, {11'h003, md});
    end
    wrw(4'h0, 16'h0000);
    pulse(7'h40, 5'h00);
    check(halt, 1'b1);
    rdw(4'h1, 16'h0063);
    rdw(4'h0, 16'h0505);
    repeat (2) @(posedge clk);
    summarize();
  end
endmodule
`default_nettype wire
